/* rtl/cscs_defines.vh */
// shared constants for the card supply class selector
`ifndef CSCS_DEFINES_VH
`define CSCS_DEFINES_VH

// reference and card clock rates
`define CSCS_REF_CLK_MHZ     200
`define CSCS_CARD_CLK_MHZ    5
`define CSCS_CARD_CLK_MIN    1
`define CSCS_CARD_CLK_MAX    5
// ref cycles per card clock half period, 50 % duty
`define CSCS_HALF_CYC        (`CSCS_REF_CLK_MHZ / (2 * `CSCS_CARD_CLK_MHZ))

// class bitmap positions in the answer-to-reset class field
`define CSCS_CLS_A           0
`define CSCS_CLS_B           1
`define CSCS_CLS_C           2
`define CSCS_CLS_D           3
`define CSCS_CLS_E           4
`define CSCS_CLS_W           3

// sequencing counts
`define CSCS_PWR_REF_CYC     1000
`define CSCS_RST_CARD_CYC    400
`define CSCS_ATR_CARD_CYC    40000
`define CSCS_DEACT_REF_CYC   1000
`define CSCS_BAD_TRIES       3
`define CSCS_CNT_W           20
`define CSCS_CNT_ONE         20'h0_0001
`define CSCS_NONE            3'h0

`endif

/* rtl/cscs_clk_div.v */
// card clock divider with rising edge tick
`timescale 1ns/1ps
`include "cscs_defines.vh"
module cscs_clk_div #(
  parameter HALF = `CSCS_HALF_CYC
) (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_run,
  output reg  o_card_clk,
  output reg  o_rise
);
  reg [7:0] cnt;

  // toggle every HALF ref cycles; held low while stopped so no runt pulse
  always @(posedge i_ref_clk) begin
    if (i_rst || !i_run) begin
      cnt        <= 8'h00;
      o_card_clk <= 1'b0;
      o_rise     <= 1'b0;
    end else if (cnt == HALF[7:0] - 8'h01) begin
      cnt        <= 8'h00;
      o_card_clk <= ~o_card_clk;   // equal halves
      o_rise     <= ~o_card_clk;
    end else begin
      cnt    <= cnt + 8'h01;
      o_rise <= 1'b0;
    end
  end
endmodule // cscs_clk_div

/* rtl/cscs_sequencer.v */
// card power-up sequencer with supply class selection
`timescale 1ns/1ps
`include "cscs_defines.vh"
module cscs_sequencer #(
  parameter HALF_CYC  = `CSCS_HALF_CYC,
  parameter PWR_CYC   = `CSCS_PWR_REF_CYC,
  parameter RST_CYC   = `CSCS_RST_CARD_CYC,
  parameter ATR_CYC   = `CSCS_ATR_CARD_CYC,
  parameter DEACT_CYC = `CSCS_DEACT_REF_CYC,
  parameter BAD_TRIES = `CSCS_BAD_TRIES
) (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_start,
  input  wire       i_stop,
  input  wire [2:0] i_term_cls,
  input  wire       i_atr_ok,
  input  wire       i_atr_bad,
  input  wire       i_atr_cls_vld,
  input  wire [7:0] i_atr_cls_fld,
  output reg        o_card_vcc_en,
  output reg  [2:0] o_vcc_sel,
  output reg        o_card_rst_n,
  output reg        o_card_clk,
  output reg        o_busy,
  output reg        o_ready,
  output reg        o_reject
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_PWR   = 3'd1;
  localparam ST_RSTLO = 3'd2;
  localparam ST_ATR   = 3'd3;
  localparam ST_DEACT = 3'd4;
  localparam ST_READY = 3'd5;
  localparam ST_REJ   = 3'd6;

  localparam [`CSCS_CNT_W-1:0] PWR_N   = PWR_CYC;
  localparam [`CSCS_CNT_W-1:0] RST_N   = RST_CYC;
  localparam [`CSCS_CNT_W-1:0] ATR_N   = ATR_CYC;
  localparam [`CSCS_CNT_W-1:0] DEACT_N = DEACT_CYC;
  localparam [1:0]             BAD_N   = BAD_TRIES;

  reg [2:0]             state;
  reg [`CSCS_CNT_W-1:0] cnt;
  reg [2:0]             cls;        // one-hot, bit0 A, bit1 B, bit2 C
  reg [2:0]             pend_cls;
  reg [2:0]             term_cls;
  reg                   pend_rej;
  reg                   first;      // still in the first activation since start
  reg                   switched;   // moved to a card-indicated class
  reg                   bad_up;     // corrupted-answer escalation used
  reg [1:0]             bad_cnt;
  wire                  clk_run;
  wire                  div_clk;
  wire                  card_tick;

  ////////////////////////////////////////////////////////////////////////
  // class helpers

  // lowest voltage in a mask: C below B below A
  function [2:0] f_lowest;
    input [2:0] m;
    begin
      if (m[`CSCS_CLS_C])
        f_lowest = 3'h4;
      else if (m[`CSCS_CLS_B])
        f_lowest = 3'h2;
      else if (m[`CSCS_CLS_A])
        f_lowest = 3'h1;
      else
        f_lowest = `CSCS_NONE;
    end
  endfunction

  // next higher supported class; cur-1 sets all higher-voltage bits
  function [2:0] f_higher;
    input [2:0] cur;
    input [2:0] supp;
    begin
      f_higher = f_lowest(supp & (cur - 3'h1));
    end
  endfunction

  wire [2:0] up_cls   = f_higher(cls, term_cls);
  // reserved classes D and E cannot be applied, only A to C used
  wire [2:0] card_cls = f_lowest(i_atr_cls_fld[`CSCS_CLS_W-1:0] & term_cls);
  wire       listed   = !i_atr_cls_vld || ((i_atr_cls_fld[`CSCS_CLS_W-1:0] & cls) != 3'h0);

  ////////////////////////////////////////////////////////////////////////
  // card clock, sourced here in the reset-low, answer and ready states, not while the supply settles

  assign clk_run = (state == ST_RSTLO) || (state == ST_ATR) || (state == ST_READY);

  cscs_clk_div #(
    .HALF (HALF_CYC)
  ) u_div (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_run      (clk_run),
    .o_card_clk (div_clk),
    .o_rise     (card_tick)
  );

  // extra register so the pin comes from a flop of this module;
  // gated by the run state so the clock drops in the same cycle as the supply
  always @(posedge i_ref_clk) begin
    if (i_rst)
      o_card_clk <= 1'b0;
    else
      o_card_clk <= div_clk & clk_run;   // HALF_CYC sets 1..5 MHz
  end

  ////////////////////////////////////////////////////////////////////////
  // activation sequencer

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      cnt      <= {`CSCS_CNT_W{1'b0}};
      cls      <= `CSCS_NONE;
      pend_cls <= `CSCS_NONE;
      term_cls <= `CSCS_NONE;
      pend_rej <= 1'b0;
      first    <= 1'b0;
      switched <= 1'b0;
      bad_up   <= 1'b0;
      bad_cnt  <= 2'h0;
    end else if (i_stop && state != ST_IDLE && state != ST_DEACT) begin
      // software abort: power down cleanly, then idle
      state    <= ST_DEACT;
      cnt      <= {`CSCS_CNT_W{1'b0}};
      pend_cls <= `CSCS_NONE;
      pend_rej <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_REJ: begin
          if (i_start) begin
            term_cls <= i_term_cls;
            cls      <= f_lowest(i_term_cls);
            first    <= 1'b1;
            switched <= 1'b0;
            bad_up   <= 1'b0;
            bad_cnt  <= 2'h0;
            cnt      <= {`CSCS_CNT_W{1'b0}};
            state    <= (f_lowest(i_term_cls) == `CSCS_NONE) ? ST_REJ : ST_PWR;
          end
        end
        ST_PWR: begin
          // supply settles before clock and reset move
          cnt <= cnt + `CSCS_CNT_ONE;
          if (cnt == PWR_N - `CSCS_CNT_ONE) begin
            cnt   <= {`CSCS_CNT_W{1'b0}};
            state <= ST_RSTLO;
          end
        end
        ST_RSTLO: begin
          if (card_tick) begin
            cnt <= cnt + `CSCS_CNT_ONE;
            if (cnt == RST_N - `CSCS_CNT_ONE) begin
              cnt   <= {`CSCS_CNT_W{1'b0}};
              state <= ST_ATR;
            end
          end
        end
        ST_ATR: begin
          // first string after reset release is taken as the answer
          if (i_atr_bad) begin
            cnt <= {`CSCS_CNT_W{1'b0}};
            if (bad_cnt != BAD_N - 2'h1) begin
              bad_cnt  <= bad_cnt + 2'h1;                 // same class again
              pend_cls <= cls;
              pend_rej <= 1'b0;
            end else if (!bad_up && up_cls != `CSCS_NONE) begin
              bad_cnt  <= 2'h0;                           // one step up only
              bad_up   <= 1'b1;
              pend_cls <= up_cls;
              pend_rej <= 1'b0;
            end else begin
              pend_rej <= 1'b1;                           // retries spent
            end
            state <= ST_DEACT;
          end else if (i_atr_ok) begin
            cnt     <= {`CSCS_CNT_W{1'b0}};
            bad_cnt <= 2'h0;
            if (listed) begin
              state <= ST_READY;
            end else if ((first || !switched) && card_cls != `CSCS_NONE) begin
              switched <= 1'b1;
              pend_cls <= card_cls;
              pend_rej <= 1'b0;
              state    <= ST_DEACT;
            end else begin
              pend_rej <= 1'b1;                           // no common class, or already switched
              state    <= ST_DEACT;
            end
          end else if (card_tick) begin
            cnt <= cnt + `CSCS_CNT_ONE;
            if (cnt == ATR_N - `CSCS_CNT_ONE) begin
              cnt      <= {`CSCS_CNT_W{1'b0}};
              bad_cnt  <= 2'h0;
              pend_cls <= up_cls;
              pend_rej <= (up_cls == `CSCS_NONE);         // classes exhausted
              state    <= ST_DEACT;
            end
          end
        end
        ST_DEACT: begin
          cnt <= cnt + `CSCS_CNT_ONE;
          if (cnt == DEACT_N - `CSCS_CNT_ONE) begin
            cnt   <= {`CSCS_CNT_W{1'b0}};
            first <= 1'b0;
            cls   <= pend_cls;
            if (pend_rej)
              state <= ST_REJ;
            else if (pend_cls == `CSCS_NONE)
              state <= ST_IDLE;
            else
              state <= ST_PWR;
          end
        end
        ST_READY: begin
          // class settled; held until stop
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pins and status

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_card_vcc_en <= 1'b0;
      o_vcc_sel     <= `CSCS_NONE;
      o_card_rst_n  <= 1'b0;
      o_busy        <= 1'b0;
      o_ready       <= 1'b0;
      o_reject      <= 1'b0;
    end else begin
      o_card_vcc_en <= (state == ST_PWR) || (state == ST_RSTLO) ||
                       (state == ST_ATR) || (state == ST_READY);
      o_vcc_sel     <= (state == ST_IDLE || state == ST_REJ || state == ST_DEACT) ?
                       `CSCS_NONE : cls;
      o_card_rst_n  <= (state == ST_ATR) || (state == ST_READY);
      o_busy        <= (state != ST_IDLE) && (state != ST_READY) && (state != ST_REJ);
      o_ready       <= (state == ST_READY);               // gate for other activity
      o_reject      <= (state == ST_REJ);
    end
  end
endmodule // cscs_sequencer

/* test/cscs_chk.sv */
// concurrent checks on the card supply class selector ports
`timescale 1ns/1ps
module cscs_chk #(parameter HALF_CYC = 4, parameter ATR_CYC = 50) (
  input wire       i_ref_clk, i_rst, i_start, i_stop, i_atr_ok, i_atr_bad, i_atr_cls_vld,
  input wire [2:0] i_term_cls,
  input wire [7:0] i_atr_cls_fld,
  input wire       o_card_vcc_en, o_card_rst_n, o_card_clk, o_busy, o_ready, o_reject,
  input wire [2:0] o_vcc_sel
);
  reg  [7:0]  hi_cnt;
  reg  [15:0] atr_cnt;
  reg         clk_q;
  wire [2:0]  low_cls = i_term_cls[2] ? 3'h4 : (i_term_cls[1] ? 3'h2 : 3'h1);
  wire        listed  = |(i_atr_cls_fld[2:0] & o_vcc_sel);
  wire        take    = o_busy && o_card_rst_n && !i_stop && i_atr_cls_vld && i_atr_ok;
  // high time and answer wait; ready stops the wait so a live session never trips it
  always @(posedge i_ref_clk) begin
    clk_q   <= o_card_clk;
    hi_cnt  <= (o_card_clk && !i_rst) ? hi_cnt + 8'h01 : 8'h00;
    atr_cnt <= (o_card_rst_n && !o_ready && !i_rst) ?
               atr_cnt + {15'h0000, o_card_clk & ~clk_q} : 16'h0000;
  end
  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_drop; ##[1:3] !o_card_vcc_en && !o_ready; endsequence
  property p_duty; $fell(o_card_clk) && o_card_vcc_en |-> hi_cnt == HALF_CYC; endproperty
  a_duty: assert property (p_duty) else $error("card clock high time off");
  property p_first; i_start && !o_busy && !o_ready && i_term_cls != 3'h0 |->
    ##[2:3] o_busy && o_vcc_sel == $past(low_cls, 2); endproperty
  a_first: assert property (p_first) else $error("first class not lowest");
  property p_off; !o_card_vcc_en |-> !o_card_clk && !o_card_rst_n && o_vcc_sel == 3'h0; endproperty
  a_off: assert property (p_off) else $error("pins active without supply");
  property p_ready; take && !i_atr_bad && listed |-> ##[2:3] o_ready && o_card_vcc_en; endproperty
  a_ready: assert property (p_ready) else $error("listed class not ready");
  property p_unlisted; take && !i_atr_bad && !listed |-> s_drop; endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted class kept");
  property p_bad; o_busy && o_card_rst_n && !i_stop && i_atr_bad |-> s_drop; endproperty
  a_bad: assert property (p_bad) else $error("corrupt answer kept");
  property p_timeout; atr_cnt <= ATR_CYC + 2; endproperty
  a_timeout: assert property (p_timeout) else $error("answer wait overrun");
  property p_reject; o_reject && !i_start && !$past(i_start) |=> o_reject && !o_card_vcc_en;
  endproperty
  a_reject: assert property (p_reject) else $error("reject not held");
endmodule // cscs_chk
bind cscs_sequencer cscs_chk #(.HALF_CYC(HALF_CYC), .ATR_CYC(ATR_CYC)) u_cscs_chk (.*);

/* test/cscs_card.sv */
// behavioural card that answers each reset release at a class that is not muted
`timescale 1ns/1ps
module cscs_card (
  input  wire       i_ref_clk,
  input  wire [2:0] i_vcc_sel,
  input  wire       i_card_rst_n,
  input  wire       i_card_clk,
  input  wire [2:0] i_mute,
  input  wire [2:0] i_bad,
  input  wire [7:0] i_fld,
  output reg        o_atr_ok = 1'b0,
  output reg        o_atr_bad = 1'b0,
  output reg        o_atr_cls_vld = 1'b0,
  output reg  [7:0] o_atr_cls_fld = 8'h00
);
  reg       clk_q;
  reg [1:0] edges;
  // answer on the third card clock rise; field shows the inverse when not sent
  always @(posedge i_ref_clk) begin
    clk_q <= i_card_clk;
    {o_atr_ok, o_atr_bad, o_atr_cls_vld} <= 3'h0;
    o_atr_cls_fld <= ~i_fld;
    if (i_card_rst_n !== 1'b1)
      edges <= 2'h0;
    else if (i_card_clk && !clk_q && edges != 2'h3) begin
      edges <= edges + 2'h1;
      if (edges == 2'h2 && (i_mute & i_vcc_sel) == 3'h0) begin
        {o_atr_bad, o_atr_ok} <= ((i_bad & i_vcc_sel) != 3'h0) ? 2'h2 : 2'h1;
        o_atr_cls_vld <= 1'b1;
        o_atr_cls_fld <= i_fld;
      end
    end
  end
endmodule // cscs_card

/* test/tb_top.sv */
// self-checking bench for the card supply class selector
`timescale 1ns/1ps
module tb_top;
  reg         i_ref_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_stop = 1'b0, en_d = 1'b0;
  reg  [2:0]  i_term_cls = 3'h0, mute = 3'h0, bad = 3'h0;
  reg  [7:0]  fld = 8'h00;
  reg  [11:0] log_w = 12'h000;
  wire        i_atr_ok, i_atr_bad, i_atr_cls_vld, o_card_vcc_en, o_card_rst_n, o_card_clk;
  wire        o_busy, o_ready, o_reject;
  wire [2:0]  o_vcc_sel;
  wire [7:0]  i_atr_cls_fld;
  integer     fail_count = 0, tests_run = 0, cyc = 0, n_up = 0, k;
  cscs_sequencer #(.HALF_CYC(4), .PWR_CYC(20), .RST_CYC(4), .ATR_CYC(50), .DEACT_CYC(20))
    u_cscs_sequencer (.*);
  cscs_card u_cscs_card (.i_ref_clk(i_ref_clk), .i_vcc_sel(o_vcc_sel), .i_card_rst_n(o_card_rst_n),
    .i_card_clk(o_card_clk), .i_mute(mute), .i_bad(bad), .i_fld(fld), .o_atr_ok(i_atr_ok),
    .o_atr_bad(i_atr_bad), .o_atr_cls_vld(i_atr_cls_vld), .o_atr_cls_fld(i_atr_cls_fld));
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  // keep the last four classes powered; the ceiling cuts a hang short
  always @(posedge i_ref_clk) begin
    en_d <= o_card_vcc_en;
    cyc <= cyc + 1;
    if (i_start === 1'b1) begin
      log_w <= 12'h000;
      n_up <= 0;
    end else if (o_card_vcc_en === 1'b1 && en_d === 1'b0) begin
      log_w <= {log_w[8:0], o_vcc_sel};
      n_up <= n_up + 1;
    end
    if (cyc == 10000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  task check(input string nm, input [21:0] seen, input [21:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // stop a live session first, since a start while ready is ignored
  task run(input [16:0] cfg);
    if (o_ready === 1'b1) begin
      i_stop = 1'b1;
      @(negedge i_ref_clk) i_stop = 1'b0;
      repeat (40) @(negedge i_ref_clk);
    end
    {i_term_cls, mute, bad, fld} = cfg;
    i_start = 1'b1;
    @(negedge i_ref_clk) i_start = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    for (k = 0; k < 4000 && o_ready !== 1'b1 && o_reject !== 1'b1; k = k + 1)
      @(negedge i_ref_clk);
  endtask
  wire [5:0] st = {o_ready, o_reject, o_card_vcc_en, o_vcc_sel};
  task t_listed;
    run({3'h6, 3'h0, 3'h0, 8'h04});
    check("listed", {st, n_up[3:0], log_w}, {6'h2C, 4'h1, 12'h004});
  endtask
  task t_switch;
    run({3'h6, 3'h0, 3'h0, 8'h1A});
    check("switch", {st, n_up[3:0], log_w}, {6'h2A, 4'h2, 12'h022});
  endtask
  task t_mute;
    run({3'h7, 3'h4, 3'h0, 8'h06});
    check("mute", {st, n_up[3:0], log_w}, {6'h2A, 4'h2, 12'h022});
  endtask
  task t_bad;
    run({3'h7, 3'h0, 3'h6, 8'h07});
    check("bad", {st, n_up[3:0], log_w}, {6'h10, 4'h6, 12'h892});
  endtask
  task t_mute_all;
    run({3'h3, 3'h7, 3'h0, 8'h03});
    check("mute_all", {st, n_up[3:0], log_w}, {6'h10, 4'h2, 12'h011});
  endtask
  // abort while the card clock runs: everything must power down to idle
  task t_stop;
    {i_term_cls, mute, bad, fld} = {3'h6, 3'h7, 3'h0, 8'h00};
    i_start = 1'b1;
    @(negedge i_ref_clk) i_start = 1'b0;
    repeat (30) @(negedge i_ref_clk);
    check("stop_busy", {o_busy, st}, {1'b1, 6'h0C});
    i_stop = 1'b1;
    @(negedge i_ref_clk) i_stop = 1'b0;
    repeat (40) @(negedge i_ref_clk);
    check("stop_idle", {o_busy, st, o_card_rst_n, o_card_clk}, 9'h000);
  endtask
  // reset in mid-activation: pins off at the first two edges after release
  task t_reset;
    {i_term_cls, mute, bad, fld} = {3'h6, 3'h0, 3'h0, 8'h04};
    i_start = 1'b1;
    @(negedge i_ref_clk) i_start = 1'b0;
    repeat (30) @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      @(negedge i_ref_clk);
      check("reset_out", {o_busy, st, o_card_rst_n, o_card_clk}, 9'h000);
    end
  endtask
  initial begin
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    t_listed;
    t_switch;
    t_mute;
    t_bad;
    t_mute_all;
    t_stop;
    t_reset;
    summarize;
  end
endmodule // tb_top
